// ### src/irc_pkg.sv
// Package for the image-rejection trim and setup block.
// Assumes a 40 MHz core clock and a plain strobe-based register port.
package irc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses, one 32-bit word each)
    localparam logic [7:0] IRC_REG0_OFF = 8'h00; // Mode / LO word
    localparam logic [7:0] IRC_REG1_OFF = 8'h04; // Reference setup
    localparam logic [7:0] IRC_REG2_OFF = 8'h08; // Transmit setup
    localparam logic [7:0] IRC_REG3_OFF = 8'h0c; // Clock setup
    localparam logic [7:0] IRC_REG4_OFF = 8'h10; // Demod setup
    localparam logic [7:0] IRC_REG5_OFF = 8'h14; // Trim word
    localparam logic [7:0] IRC_REG6_OFF = 8'h18; // Tone setup
    localparam logic [7:0] IRC_STAT_OFF = 8'h1c; // Status / strength readback
    localparam logic [7:0] IRC_CAL_OFF = 8'h20; // Calibration control

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int IRC_PH_MAG_LSB = 20; // Phase trim magnitude, 4 bits
    localparam int IRC_PH_SEL_BIT = 24; // Phase trim channel select
    localparam int IRC_GN_MAG_LSB = 25; // Gain trim magnitude, 5 bits
    localparam int IRC_GN_SEL_BIT = 30; // Gain trim channel select
    localparam int IRC_GN_POL_BIT = 31; // Gain trim polarity
    localparam int IRC_DRV_LSB = 28; // Internal tone drive level, 2 bits
    localparam int IRC_TONE_MUL_LSB = 4; // Tone odd-multiple index, 8 bits
    localparam int IRC_DIR_BIT = 27; // Direction bit in register 0
    localparam logic [1:0] IRC_DRV_MAX = 2'h3; // Maximum drive code

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and frequency constants
    localparam logic [31:0] IRC_REG_RST = 32'h0000_0000;
    localparam logic [23:0] IRC_IMAGE_KHZ = 24'h0000c8; // Image offset, 200 kHz
    localparam logic [23:0] IRC_TRX_KHZ = 24'h000064; // Tx/Rx LO shift, 100 kHz

    // Setup progress states
    typedef enum logic [2:0]
    {
        IRC_SU_IDLE = 3'b000,
        IRC_SU_R1 = 3'b001,
        IRC_SU_R3 = 3'b010,
        IRC_SU_R0 = 3'b011,
        IRC_SU_R5 = 3'b100,
        IRC_SU_TX_OK = 3'b101,
        IRC_SU_RX_OK = 3'b110
    } irc_setup_t;

    // Trim applied to the I/Q path
    typedef struct packed
    {
        logic [3:0] phase_trim_magnitude;
        logic phase_trim_channel_select;
        logic [4:0] gain_trim_magnitude;
        logic gain_trim_channel_select;
        logic gain_trim_polarity;
    } irc_trim_t;

    // Receive-chain control during calibration
    typedef struct packed
    {
        logic lna_power_on;
        logic tone_enable;
        logic [1:0] tone_drive;
        logic [7:0] tone_multiple;
        logic [23:0] lo_offset_khz;
        logic lo_offset_negative;
    } irc_rf_ctl_t;

endpackage : irc_pkg

// ### src/irc_core.sv
// Trim register file, calibration control and setup tracking.
// Assumes registers are written by a local master on the same clock;
// strength, filter gain and amplifier gain come from on-chip logic.
//
// Overview of operation
// [R1] Controller sets tone drive to maximum
// [R2] Controller sets LNA minimum gain, AGC off
// [R3] Phase magnitude from trim bits 20-23
// [R4] Bit 24 picks channel for phase
// [R5] Gain magnitude from trim bits 25-29
// [R6] Bit 30 picks channel for gain
// [R7] Bit 31 selects gain up or down
// [R8] Controller searches codes for lowest strength
// [R9] Calibration: LNA off, LO at image
// [R10] Tone at odd multiples of reference
// [R11] External source: same search, LNA input
// [R12] Setup order 1,3,0,2 or 1,3,0,5,4
// [R13] Direction toggle via register 0 shifts LO
// [R14] Controller recalibrates after temperature drift
// [R15] Readback: strength low seven, gains above
// [R16] Controller waits for strength to settle
//
// Notes for the next user of this block:
// - trim and RF control lag a write by two enabled edges,
//   one for the word register and one for the output flop
// - the strength read just after a trim write is stale;
//   the far side needs time before its level settles
// - reads of unmapped offsets return zero
// - writes to unmapped offsets and to the status word are dropped
// - setting both calibration bits selects the internal source only
// - the setup tracker only watches writes; it never blocks one
// - a write out of order leaves the tracker where it is
// - chip enable is asynchronous and passes two flops before use
// - with clk_en low every register, read data included, holds still
// - read data is zero in every cycle that follows an enabled cycle without a read
`timescale 1ns/10ps

module irc_core
    import irc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [6:0] strength_level,
    input wire logic [1:0] filter_gain,
    input wire logic [1:0] amp_gain,
    input wire logic chip_enable,
    output irc_trim_t trim,
    output irc_rf_ctl_t rf_ctl,
    output logic transmit_mode,
    output logic setup_done
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [31:0] regs_r [0:6]; // Configuration words 0..6
    logic [31:0] reg_rdata_r; // Read data, one cycle late
    logic cal_en_r; // Internal-source calibration on
    logic cal_ext_r; // External-source calibration on
    irc_setup_t setup_r; // Setup progress
    irc_setup_t setup_nxt;
    logic [1:0] ce_sync_r; // Chip enable synchroniser
    logic ce_prev_r; // Previous synchronised level
    irc_trim_t trim_r; // Trim held in flops
    irc_rf_ctl_t rf_ctl_r; // RF control held in flops
    logic dir_r; // Direction bit mirror

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic [2:0] irc_index(input logic [7:0] a);
        irc_index = a[4:2];
    endfunction : irc_index

    // Words 0..6 sit below the status word
    wire cfg_hit = (reg_addr[7:5] == 3'h0) && (reg_addr != IRC_STAT_OFF);
    // Calibration control word
    wire cal_hit = (reg_addr == IRC_CAL_OFF);
    // Read-only strength and status word
    wire stat_hit = (reg_addr == IRC_STAT_OFF);
    // Word index of the access
    wire [2:0] wr_idx = irc_index(reg_addr);
    // Write to a configuration word
    wire cfg_wr = reg_wr && cfg_hit;
    // Chip enable rising, after synchronisation
    wire ce_rise = ce_sync_r[1] && !ce_prev_r;
    // Trim word
    wire [31:0] r5_w = regs_r[5];
    // Tone setup word
    wire [31:0] r6_w = regs_r[6];
    // Either calibration source active
    wire cal_any = cal_en_r || cal_ext_r;
    // Zero tone index keeps the tone off
    wire odd_valid = (r6_w[IRC_TONE_MUL_LSB +: 8] != 8'h00);

    // Readback word: strength low, gains above
    wire [31:0] stat_word = {19'h00000, setup_done, transmit_mode, amp_gain, filter_gain,
        strength_level}; // R15

    // Read mux; unmapped reads return zero
    wire [31:0] rd_mux = stat_hit ? stat_word :
        cal_hit ? {30'h0, cal_ext_r, cal_en_r} :
        cfg_hit ? regs_r[wr_idx] : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // Config register writes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 7; i++)
            begin
                regs_r[i] <= IRC_REG_RST;
            end
        end
        else if (clk_en && cfg_wr)
        begin
            regs_r[wr_idx] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration control and read data
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cal_en_r <= 1'b0;
            cal_ext_r <= 1'b0;
            reg_rdata_r <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            // Internal source wins when both bits are set
            if (reg_wr && cal_hit)
            begin
                cal_en_r <= reg_wdata[0];
                cal_ext_r <= reg_wdata[1] && !reg_wdata[0];
            end
            // Data stands for one cycle only
            reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    assign reg_rdata = reg_rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Chip enable synchroniser
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ce_sync_r <= 2'h0;
            ce_prev_r <= 1'b0;
        end
        else if (clk_en)
        begin
            ce_sync_r <= {ce_sync_r[0], chip_enable};
            ce_prev_r <= ce_sync_r[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setup progress after chip enable rises
    always_comb
    begin
        setup_nxt = setup_r;
        if (ce_rise)
        begin
            setup_nxt = IRC_SU_R1; // R12
        end
        else if (cfg_wr)
        begin
            unique case (setup_r)
                IRC_SU_IDLE: setup_nxt = IRC_SU_IDLE;
                IRC_SU_R1: setup_nxt = (wr_idx == 3'h1) ? IRC_SU_R3 : IRC_SU_R1; // R12
                IRC_SU_R3: setup_nxt = (wr_idx == 3'h3) ? IRC_SU_R0 : IRC_SU_R3; // R12
                IRC_SU_R0: // Branch on next register
                begin
                    if (wr_idx == 3'h2)
                    begin
                        setup_nxt = IRC_SU_TX_OK; // R12
                    end
                    else if (wr_idx == 3'h5)
                    begin
                        setup_nxt = IRC_SU_R5; // R12
                    end
                end
                IRC_SU_R5: setup_nxt = (wr_idx == 3'h4) ? IRC_SU_RX_OK : IRC_SU_R5; // R12
                IRC_SU_TX_OK: setup_nxt = IRC_SU_TX_OK;
                IRC_SU_RX_OK: setup_nxt = IRC_SU_RX_OK;
                default: setup_nxt = IRC_SU_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            setup_r <= IRC_SU_IDLE;
        end
        else if (clk_en)
        begin
            setup_r <= setup_nxt;
        end
    end

    assign setup_done = (setup_r == IRC_SU_TX_OK) || (setup_r == IRC_SU_RX_OK);

    ////////////////////////////////////////////////////////////////////////////
    // Next values for the output flops
    // Phase correction size
    wire [3:0] ph_mag_nxt = r5_w[IRC_PH_MAG_LSB +: 4]; // R3
    // Channel that takes the phase correction
    wire ph_sel_nxt = r5_w[IRC_PH_SEL_BIT]; // R4
    // Amplitude correction size
    wire [4:0] gn_mag_nxt = r5_w[IRC_GN_MAG_LSB +: 5]; // R5
    // Channel that takes the amplitude correction
    wire gn_sel_nxt = r5_w[IRC_GN_SEL_BIT]; // R6
    // Gain increase or attenuation
    wire gn_pol_nxt = r5_w[IRC_GN_POL_BIT]; // R7
    // Trim fields in struct order
    irc_trim_t trim_nxt;
    assign trim_nxt = {ph_mag_nxt, ph_sel_nxt, gn_mag_nxt, gn_sel_nxt, gn_pol_nxt};
    // Index n gives tone at (2n-1) x reference
    wire [7:0] tone_mul_nxt = {r6_w[IRC_TONE_MUL_LSB +: 7], 1'b1} - 8'h02; // R10
    // Direction bit of register 0
    wire dir_nxt = regs_r[0][IRC_DIR_BIT]; // R13
    // Tx/Rx shift by direction
    wire [23:0] trx_khz_nxt = dir_nxt ? IRC_TRX_KHZ : 24'h000000; // R13
    // Image offset wins during calibration
    wire [23:0] lo_khz_nxt = cal_any ? IRC_IMAGE_KHZ : trx_khz_nxt; // R9
    // Image lies below the wanted signal
    wire lo_neg_nxt = cal_any; // R9

    ////////////////////////////////////////////////////////////////////////////
    // Trim and RF control outputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            trim_r <= '0;
            rf_ctl_r <= '0;
            dir_r <= 1'b0;
        end
        else if (clk_en)
        begin
            trim_r <= trim_nxt; // R3 R4 R5 R6 R7
            dir_r <= dir_nxt; // R13
            // LNA off only for internal tone
            rf_ctl_r.lna_power_on <= !cal_en_r; // R9
            rf_ctl_r.tone_enable <= cal_en_r && odd_valid; // R10
            rf_ctl_r.tone_drive <= r6_w[IRC_DRV_LSB +: 2]; // R1
            rf_ctl_r.tone_multiple <= tone_mul_nxt; // R10
            rf_ctl_r.lo_offset_khz <= lo_khz_nxt; // R9 R13
            rf_ctl_r.lo_offset_negative <= lo_neg_nxt; // R9
        end
    end

    assign trim = trim_r;
    assign rf_ctl = rf_ctl_r;
    assign transmit_mode = dir_r;

endmodule : irc_core

// ### tb/irc_core_properties.sv
// Port checks for the trim and setup block.
// Assumes clk_en is high; the bench drops it only in its freeze test.
`timescale 1ns/10ps

module irc_core_properties
    import irc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [6:0] strength_level,
    input wire logic [1:0] filter_gain,
    input wire logic [1:0] amp_gain,
    input wire irc_trim_t trim,
    input wire irc_rf_ctl_t rf_ctl,
    input wire logic transmit_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire logic t_wr = clk_en && reg_wr && reg_addr == IRC_REG5_OFF; // Trim word write
    AST_PH_MAG: assert property (t_wr |-> ##2 trim[11:8] == $past(reg_wdata[23:20], 2))
        else $error("phase trim magnitude wrong");
    AST_TRIM_REST: assert property (t_wr |-> ##2 trim[7:0] ==
        $past({reg_wdata[24], reg_wdata[29:25], reg_wdata[30], reg_wdata[31]}, 2))
        else $error("trim select or gain wrong");
    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    AST_STAT: assert property (clk_en && reg_rd && reg_addr == IRC_STAT_OFF |=>
        reg_rdata[10:0] == $past({amp_gain, filter_gain, strength_level}))
        else $error("strength readback wrong");
    AST_CAL_IMG: assert property ($fell(rf_ctl.lna_power_on) |->
        rf_ctl.lo_offset_negative && rf_ctl.lo_offset_khz == IRC_IMAGE_KHZ)
        else $error("calibration LO not at image");
    AST_TONE_ODD: assert property (rf_ctl.tone_enable |-> rf_ctl.tone_multiple[0])
        else $error("tone multiple even");
    AST_DIR: assert property (clk_en && reg_wr && reg_addr == IRC_REG0_OFF |->
        ##2 transmit_mode == $past(reg_wdata[IRC_DIR_BIT], 2))
        else $error("direction not taken");
    AST_TRX_LO: assert property ($rose(transmit_mode) && rf_ctl.lna_power_on |->
        ##[0:2] (rf_ctl.lo_offset_khz == IRC_TRX_KHZ && !rf_ctl.lo_offset_negative))
        else $error("direction LO shift wrong");
    COV_CAL: cover property ($fell(rf_ctl.lna_power_on));
    COV_TX: cover property ($rose(transmit_mode));
    COV_STAT: cover property (reg_rd && reg_addr == IRC_STAT_OFF);
endmodule : irc_core_properties

bind irc_core irc_core_properties u_props (.clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strength_level, .filter_gain, .amp_gain, .trim, .rf_ctl, .transmit_mode);

// ### tb/irc_strength_model.sv
// Far-side strength source: level grows with distance from the best trim.
// Assumes trim comes straight from the block under test.
`timescale 1ns/10ps

module irc_strength_model
    import irc_pkg::*;
#(
    parameter logic [3:0] BEST_PH = 4'h9,
    parameter logic [4:0] BEST_GN = 5'h0c
)
(
    input wire logic clk,
    input wire irc_trim_t trim,
    output logic [6:0] strength_level,
    output logic [1:0] filter_gain,
    output logic [1:0] amp_gain
);
    wire logic [3:0] ph = trim[11:8]; // Phase code
    wire logic [4:0] gn = trim[6:2]; // Gain code
    assign filter_gain = 2'h2; // Fixed filter gain
    assign amp_gain = 2'h1; // Low amplifier gain
    // Level settles one edge after a new trim
    always_ff @(posedge clk) strength_level <= 7'h05 + 7'(ph > BEST_PH ? ph - BEST_PH : BEST_PH - ph)
        + 7'(gn > BEST_GN ? gn - BEST_GN : BEST_GN - gn);
endmodule : irc_strength_model

// ### tb/tb_irc_core.sv
// Self-checking bench for the trim and setup block.
// Assumes the strength model on the far side; clk_en high except in t_freeze.
`timescale 1ns/10ps

module tb_irc_core
    import irc_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0, chip_enable = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [6:0] strength_level;
    logic [1:0] filter_gain, amp_gain;
    logic transmit_mode, setup_done;
    irc_trim_t trim;
    irc_rf_ctl_t rf_ctl;
    int fail_count = 0, n_tests = 0;
    logic [7:0] ord [5] = '{IRC_REG1_OFF, IRC_REG3_OFF, IRC_REG0_OFF, IRC_REG5_OFF, IRC_REG4_OFF};
    logic [31:0] tw [3] = '{32'hf5a0_0000, 32'h0a50_0000, 32'h8170_0000};
    irc_core uut (.clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .strength_level, .filter_gain, .amp_gain, .chip_enable, .trim, .rf_ctl, .transmit_mode, .setup_done);
    irc_strength_model u_model (.clk, .trim, .strength_level, .filter_gain, .amp_gain);
    initial forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [39:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One bus access; read data lands in d
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] v);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask : acc
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_setup();
        chip_enable <= 1'b1;
        idle(4);
        chk("setup early", setup_done, 1'b0);
        foreach (ord[i]) acc(1'b1, ord[i], 32'h0);
        idle(1);
        acc(1'b0, IRC_STAT_OFF, 32'h0);
        chk("setup done", d[12:11], 2'h2);
        $display("setup test done");
    endtask : t_setup
    task automatic t_trx();
        acc(1'b1, IRC_REG0_OFF, 32'h1 << IRC_DIR_BIT);
        idle(2);
        chk("tx lo", {transmit_mode, rf_ctl.lo_offset_negative, rf_ctl.lo_offset_khz}, {2'h2, IRC_TRX_KHZ});
        acc(1'b1, IRC_REG0_OFF, 32'h0);
        idle(2);
        chk("rx mode", transmit_mode, 1'b0);
        $display("direction test done");
    endtask : t_trx
    task automatic t_trim();
        foreach (tw[i])
        begin
            acc(1'b1, IRC_REG5_OFF, tw[i]);
            idle(2);
            chk("trim", trim, {tw[i][23:20], tw[i][24], tw[i][29:25], tw[i][30], tw[i][31]});
        end
        acc(1'b0, IRC_REG5_OFF, 32'h0);
        chk("trim read", d, tw[2]);
        acc(1'b1, 8'h40, 32'hffff_ffff);
        acc(1'b0, 8'h40, 32'h0);
        idle(1);
        chk("unmapped", d, 32'h0);
        $display("trim test done");
    endtask : t_trim
    // Write with clock enable low must leave the trim alone
    task automatic t_freeze();
        clk_en <= 1'b0;
        acc(1'b1, IRC_REG5_OFF, 32'h0);
        idle(2);
        chk("frozen trim", trim, {tw[2][23:20], tw[2][24], tw[2][29:25], tw[2][30], tw[2][31]});
        clk_en <= 1'b1;
        idle(2);
        chk("after freeze", trim, {tw[2][23:20], tw[2][24], tw[2][29:25], tw[2][30], tw[2][31]});
        $display("freeze test done");
    endtask : t_freeze
    task automatic t_cal();
        acc(1'b1, IRC_REG6_OFF, {2'h0, IRC_DRV_MAX, 16'h0, 8'h03, 4'h0});
        acc(1'b1, IRC_CAL_OFF, 32'h3);
        idle(2);
        chk("int cal", rf_ctl, {2'h1, IRC_DRV_MAX, 8'h05, IRC_IMAGE_KHZ, 1'b1});
        acc(1'b1, IRC_CAL_OFF, 32'h2);
        idle(2);
        chk("ext cal", {rf_ctl.lna_power_on, rf_ctl.lo_offset_khz, rf_ctl.lo_offset_negative},
            {1'b1, IRC_IMAGE_KHZ, 1'b1});
        acc(1'b1, IRC_CAL_OFF, 32'h0);
        idle(2);
        $display("calibration test done");
    endtask : t_cal
    task automatic t_search();
        logic [6:0] best = 7'h7f;
        logic [8:0] code = 9'h0;
        for (int c = 0; c < 512; c++)
        begin
            acc(1'b1, IRC_REG5_OFF, {2'h0, c[8:4], 1'b0, c[3:0], 20'h0});
            idle(3);
            acc(1'b0, IRC_STAT_OFF, 32'h0);
            if (d[6:0] < best)
            begin
                best = d[6:0];
                code = c[8:0];
            end
        end
        idle(1);
        chk("best code", code, 9'h0c9);
        chk("best level", {d[10:7], best}, {4'h6, 7'h05});
        $display("search test done");
    endtask : t_search
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(25 * 10000);
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        idle(1);
        t_setup();
        t_trx();
        t_trim();
        t_freeze();
        t_cal();
        t_search();
        t_search(); // Rerun as after temperature drift
        close_out();
    end
endmodule : tb_irc_core
